//--- hw/aaco_pwm_channel.sv
module aaco_pwm_channel #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [CNT_W-1:0] period,
  input wire logic [14:0] level,
  output logic out_pos,
  output logic out_neg,
  output logic wrap
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic next_pos;
  logic [CNT_W+14:0] product;
  logic [CNT_W-1:0] thr;

  // Duty threshold, one count per carrier tick
  always_comb begin
    product = {{CNT_W{1'b0}}, level} * {15'h0000, period};
    thr = product[CNT_W+14:15];
    wrap = (cnt >= period - {{(CNT_W-1){1'b0}}, 1'b1});
    next_cnt = wrap ? '0 : cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    next_pos = (next_cnt < thr);
  end

  // Carrier counter and complementary pin pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      out_pos <= 1'b0;
      out_neg <= 1'b1;
    end else begin
      cnt <= next_cnt;
      out_pos <= next_pos;
      out_neg <= ~next_pos;
    end
  end
endmodule

//--- hw/aaco_top.sv
// Function
// - PWM set value -16384..16383 maps to full scale
// - Carrier equals phase clock times (multiplier+1)/2
// - Effective resolution equals carrier period in ticks
// - Converter set value -32768..32767 maps to full scale
// - Each converter step gives distinct output code
// - Drive link settings reset to 5/FFFFC/0/2
// - Negative output is inverse of positive output
// - Link sends current command, reads back current
module aaco_top #(
  parameter int unsigned PHASE_CYC = aaco_pkg::PHASE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic analog_out_a_pos,
  output logic analog_out_a_neg,
  output logic [15:0] dac_code_pos,
  output logic [15:0] dac_code_neg,
  output aaco_pkg::aaco_link_out_s link_out,
  input wire logic link_fb
);
  import aaco_pkg::*;

  aaco_mode_e mode, next_mode;
  logic [2:0] carrier_multiplier, next_mult;
  logic signed [15:0] set_value, next_set;
  aaco_drive_cfg_s drive_cfg, next_cfg;
  logic [15:0] cur_cmd, next_cur_cmd;
  logic [15:0] cur_fb, next_cur_fb;
  logic [31:0] next_prdata;
  logic cfg_written, next_cfg_written;
  logic wr_en, rd_setup, mapped;

  // APB decode, zero wait states
  always_comb begin
    wr_en = psel && penable && pwrite;
    rd_setup = psel && !penable && !pwrite;
    mapped = (paddr == OFS_CTRL) || (paddr == OFS_SETVAL) || (paddr == OFS_LINK_CFG) ||
             (paddr == OFS_STROBE) || (paddr == OFS_CUR_CMD) || (paddr == OFS_CUR_FB) ||
             (paddr == OFS_STATUS);
    pready = 1'b1;
    pslverr = psel && penable && !mapped;
  end

  logic phase_tick;
  logic [15:0] phase_cnt;
  logic link_busy;

  // Register writes and read data capture
  always_comb begin
    next_mode = mode;
    next_mult = carrier_multiplier;
    next_set = set_value;
    next_cfg = drive_cfg;
    next_cfg_written = cfg_written;
    next_cur_cmd = cur_cmd;
    next_prdata = prdata;
    if (wr_en) begin
      case (paddr)
        OFS_CTRL: begin
          next_mode = aaco_mode_e'(pwdata[CTRL_MODE_BIT]);
          next_mult = pwdata[CTRL_MULT_LSB +: 3];
        end
        OFS_SETVAL: next_set = pwdata[15:0];
        OFS_LINK_CFG: begin
          next_cfg.div = pwdata[CFG_DIV_LSB +: 4];
          next_cfg.delay = pwdata[CFG_DELAY_LSB +: 4];
          next_cfg.header = pwdata[CFG_HEADER_LSB +: 3];
          next_cfg_written = 1'b1;
        end
        OFS_STROBE: begin
          next_cfg.strobe = pwdata[19:0];
          next_cfg_written = 1'b1;
        end
        OFS_CUR_CMD: next_cur_cmd = pwdata[15:0];
        default: ;
      endcase
    end
    if (rd_setup) begin
      next_prdata = 32'h0000_0000;
      case (paddr)
        OFS_CTRL: next_prdata = {28'h0000000, carrier_multiplier, mode};
        OFS_SETVAL: next_prdata = {16'h0000, set_value};
        OFS_LINK_CFG: next_prdata = {21'h000000, drive_cfg.header, drive_cfg.delay,
                                     drive_cfg.div};
        OFS_STROBE: next_prdata = {12'h000, drive_cfg.strobe};
        OFS_CUR_CMD: next_prdata = {16'h0000, cur_cmd};
        OFS_CUR_FB: next_prdata = {16'h0000, cur_fb};
        OFS_STATUS: next_prdata = {29'h00000000, mode, link_busy, analog_out_a_pos};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Register file storage; drive link defaults at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= AACO_MODE_PWM;
      carrier_multiplier <= 3'h0;
      set_value <= 16'sh0000;
      drive_cfg <= CFG_RST;
      cfg_written <= 1'b0;
      cur_cmd <= 16'h0000;
      prdata <= 32'h0000_0000;
    end else begin
      mode <= next_mode;
      carrier_multiplier <= next_mult;
      set_value <= next_set;
      drive_cfg <= next_cfg;
      cfg_written <= next_cfg_written;
      cur_cmd <= next_cur_cmd;
      prdata <= next_prdata;
    end
  end

  // Internal phase clock as a tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_cnt <= 16'h0000;
    end else begin
      phase_cnt <= phase_tick ? 16'h0000 : phase_cnt + 16'h0001;
    end
  end
  assign phase_tick = (phase_cnt >= 16'(PHASE_CYC - 1));

  // Carrier period and clamped duty level
  logic [CNT_W-1:0] period;
  logic [14:0] pwm_level;
  logic signed [15:0] clamped;
  logic [15:0] offs;
  logic carrier_wrap;
  always_comb begin
    period = CNT_W'((2 * PHASE_CYC) / ({29'h0, carrier_multiplier} + 32'd1));
    if (set_value < PWM_SET_MIN) clamped = PWM_SET_MIN;
    else if (set_value > PWM_SET_MAX) clamped = PWM_SET_MAX;
    else clamped = set_value;
    offs = clamped + PWM_SET_OFS;
    pwm_level = (mode == AACO_MODE_PWM) ? offs[14:0] : PWM_LEVEL_ZERO;
  end

  aaco_pwm_channel #(.CNT_W(CNT_W)) u_pwm (
    .pclk(pclk),
    .presetn(presetn),
    .period(period),
    .level(pwm_level),
    .out_pos(analog_out_a_pos),
    .out_neg(analog_out_a_neg),
    .wrap(carrier_wrap)
  );

  // Converter codes, offset binary, updated on phase tick
  logic [15:0] next_dac;
  always_comb begin
    next_dac = dac_code_pos;
    if (phase_tick) begin
      next_dac = (mode == AACO_MODE_DAC) ? (set_value ^ DAC_SIGN) : DAC_ZERO;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_code_pos <= DAC_ZERO;
      dac_code_neg <= ~DAC_ZERO;
    end else begin
      dac_code_pos <= next_dac;
      dac_code_neg <= ~next_dac;
    end
  end

  // Feedback pin synchroniser
  logic fb_meta, fb_sync;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_meta <= 1'b0;
      fb_sync <= 1'b0;
    end else begin
      fb_meta <= link_fb;
      fb_sync <= fb_meta;
    end
  end

  // Drive link frame engine, one frame per phase tick
  aaco_link_state_e lstate, next_lstate;
  logic [4:0] tcnt, next_tcnt, slot, next_slot;
  logic [15:0] fb_shift, next_fb_shift;
  logic [4:0] bitper;
  logic slot_end, frame_done, in_cmd;
  aaco_link_out_s next_link;
  always_comb begin
    bitper = (drive_cfg.div == 4'h0) ? 5'h02 : {drive_cfg.div, 1'b0};
    slot_end = (tcnt == bitper - 5'h01);
    in_cmd = (slot >= {2'b00, drive_cfg.header}) &&
             (slot < {2'b00, drive_cfg.header} + CMD_BITS);
    next_lstate = lstate;
    next_tcnt = slot_end ? 5'h00 : tcnt + 5'h01;
    next_slot = slot;
    next_fb_shift = fb_shift;
    next_cur_fb = cur_fb;
    frame_done = 1'b0;
    case (lstate)
      AACO_LNK_IDLE: begin
        next_tcnt = 5'h00;
        next_slot = 5'h00;
        if (phase_tick) begin
          next_lstate = (drive_cfg.delay == 4'h0) ? AACO_LNK_SHIFT : AACO_LNK_WAIT;
        end
      end
      AACO_LNK_WAIT: begin
        if (slot_end) begin
          next_slot = slot + 5'h01;
          if (slot + 5'h01 >= {1'b0, drive_cfg.delay}) begin
            next_lstate = AACO_LNK_SHIFT;
            next_slot = 5'h00;
          end
        end
      end
      AACO_LNK_SHIFT: begin
        if (slot_end) begin
          if (in_cmd) next_fb_shift = {fb_shift[14:0], fb_sync};
          next_slot = slot + 5'h01;
          if (slot == LINK_SLOTS - 5'h01) begin
            frame_done = 1'b1;
            next_cur_fb = in_cmd ? {fb_shift[14:0], fb_sync} : fb_shift;
            next_lstate = AACO_LNK_IDLE;
          end
        end
      end
      default: next_lstate = AACO_LNK_IDLE;
    endcase
    next_link.sclk = (next_lstate == AACO_LNK_SHIFT) && (next_tcnt >= (bitper >> 1));
    next_link.strobe = (next_lstate == AACO_LNK_SHIFT) &&
                       drive_cfg.strobe[LINK_SLOTS - 5'h01 - next_slot];
    next_link.cmd = 1'b0;
    if ((next_lstate == AACO_LNK_SHIFT) && (next_slot >= {2'b00, drive_cfg.header}) &&
        (next_slot < {2'b00, drive_cfg.header} + CMD_BITS)) begin
      next_link.cmd = cur_cmd[4'hf - 4'(next_slot - {2'b00, drive_cfg.header})];
    end
  end
  assign link_busy = (lstate != AACO_LNK_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lstate <= AACO_LNK_IDLE;
      tcnt <= 5'h00;
      slot <= 5'h00;
      fb_shift <= 16'h0000;
      cur_fb <= 16'h0000;
      link_out <= '0;
    end else begin
      lstate <= next_lstate;
      tcnt <= next_tcnt;
      slot <= next_slot;
      fb_shift <= next_fb_shift;
      cur_fb <= next_cur_fb;
      link_out <= next_link;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pin_inverse: assert property (analog_out_a_neg == !analog_out_a_pos)
    else $error("pwm pin pair not complementary");
  a_dac_inverse: assert property (dac_code_neg == ~dac_code_pos)
    else $error("converter pair not inverse");
  a_dac_code_map: assert property ((phase_tick && mode == AACO_MODE_DAC) |=>
      dac_code_pos == ($past(set_value) ^ 16'h8000))
    else $error("converter code does not follow set value");
  a_pwm_zero_mid: assert property ((mode == AACO_MODE_PWM && set_value == 16'sh0000) |->
      pwm_level == 15'h4000)
    else $error("zero set value not at half duty");
  a_pwm_full_clamp: assert property ((mode == AACO_MODE_PWM && set_value > 16'sh3fff) |->
      pwm_level == 15'h7fff)
    else $error("pwm full scale not clamped");
  a_carrier_period: assert property ((carrier_multiplier == 3'h7) |->
      period == CNT_W'((2 * PHASE_CYC) / 8))
    else $error("carrier period wrong for top multiplier");
  a_cfg_default: assert property (!cfg_written |->
      (drive_cfg.div == 4'h5 && drive_cfg.strobe == 20'hffffc &&
       drive_cfg.delay == 4'h0 && drive_cfg.header == 3'h2))
    else $error("drive link defaults lost");
  a_link_fb_take: assert property (frame_done |=> (cur_fb == $past(next_cur_fb)) &&
      lstate == AACO_LNK_IDLE)
    else $error("feedback not latched at frame end");
  a_link_idle_quiet: assert property ((lstate == AACO_LNK_IDLE) |=>
      !$past(link_out.sclk) || lstate != AACO_LNK_IDLE)
    else $error("link clock active while idle");

  c_dac_mode: cover property (phase_tick && mode == AACO_MODE_DAC);
  c_frame_done: cover property (frame_done);
  c_carrier_wrap: cover property (carrier_wrap && mode == AACO_MODE_PWM);
endmodule

//--- include/aaco_pkg.sv
package aaco_pkg;
  // Timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned PHASE_HZ = 10_000;
  localparam int unsigned PHASE_CYCLES = CLK_HZ / PHASE_HZ;
  localparam int unsigned CNT_W = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SETVAL = 8'h04;
  localparam logic [7:0] OFS_LINK_CFG = 8'h08;
  localparam logic [7:0] OFS_STROBE = 8'h0c;
  localparam logic [7:0] OFS_CUR_CMD = 8'h10;
  localparam logic [7:0] OFS_CUR_FB = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // Field positions
  localparam int unsigned CTRL_MODE_BIT = 0;
  localparam int unsigned CTRL_MULT_LSB = 1;
  localparam int unsigned CFG_DIV_LSB = 0;
  localparam int unsigned CFG_DELAY_LSB = 4;
  localparam int unsigned CFG_HEADER_LSB = 8;
  localparam int unsigned STAT_PWM_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 1;
  localparam int unsigned STAT_MODE_BIT = 2;

  // Set value ranges and codes
  localparam logic signed [15:0] PWM_SET_MIN = 16'shc000;
  localparam logic signed [15:0] PWM_SET_MAX = 16'sh3fff;
  localparam logic [15:0] PWM_SET_OFS = 16'h4000;
  localparam logic [14:0] PWM_LEVEL_ZERO = 15'h4000;
  localparam logic [15:0] DAC_SIGN = 16'h8000;
  localparam logic [15:0] DAC_ZERO = 16'h8000;

  // Drive link defaults and frame shape
  localparam logic [3:0] DIV_RST = 4'h5;
  localparam logic [19:0] STROBE_RST = 20'hffffc;
  localparam logic [3:0] DELAY_RST = 4'h0;
  localparam logic [2:0] HEADER_RST = 3'h2;
  localparam logic [4:0] LINK_SLOTS = 5'h14;
  localparam logic [4:0] CMD_BITS = 5'h10;

  typedef enum logic [0:0] {
    AACO_MODE_PWM = 1'b0,
    AACO_MODE_DAC = 1'b1
  } aaco_mode_e;

  typedef enum logic [2:0] {
    AACO_LNK_IDLE = 3'b001,
    AACO_LNK_WAIT = 3'b010,
    AACO_LNK_SHIFT = 3'b100
  } aaco_link_state_e;

  typedef struct packed {
    logic [19:0] strobe;
    logic [3:0] delay;
    logic [2:0] header;
    logic [3:0] div;
  } aaco_drive_cfg_s;

  localparam aaco_drive_cfg_s CFG_RST = '{strobe: STROBE_RST, delay: DELAY_RST,
                                         header: HEADER_RST, div: DIV_RST};

  typedef struct packed {
    logic sclk;
    logic strobe;
    logic cmd;
  } aaco_link_out_s;
endpackage

//--- verif/aaco_drive_model.sv
module aaco_drive_model #(
  parameter int HDR = 2
) (
  input wire logic pclk,
  input wire aaco_pkg::aaco_link_out_s link_out,
  input wire logic [15:0] fb_word,
  output logic link_fb,
  output logic [15:0] cmd_seen,
  output logic [19:0] strobe_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  import aaco_pkg::*;
  int slot;
  int idle;
  logic sclk_q;
  initial begin
    link_fb = 1'b0;
    cmd_seen = 16'h0000;
    strobe_seen = 20'h00000;
    slot = 0;
    idle = 0;
    sclk_q = 1'b0;
  end
  // Counts slots per frame, answers current MSB first, idles toggled
  always @(posedge pclk) begin
    sclk_q <= link_out.sclk;
    idle <= link_out.sclk ? 0 : idle + 1;
    if (idle > 40) slot <= 0;
    if (link_out.sclk && !sclk_q) begin
      slot <= slot + 1;
      strobe_seen <= {strobe_seen[18:0], link_out.strobe};
      if (slot >= HDR && slot < HDR + 16) begin
        link_fb <= fb_word[15 - (slot - HDR)];
        cmd_seen <= {cmd_seen[14:0], link_out.cmd};
      end else begin
        link_fb <= ~link_fb;
      end
    end
  end
endmodule

//--- verif/axis_analog_command_output_test.sv
module axis_analog_command_output_test;
  timeunit 1ns;
  timeprecision 1ps;
  import aaco_pkg::*;
  localparam int PC = 400;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic analog_out_a_pos;
  logic analog_out_a_neg;
  logic [15:0] dac_code_pos;
  logic [15:0] dac_code_neg;
  aaco_link_out_s link_out;
  logic link_fb;
  logic [15:0] fb_word = 16'h3c96;
  logic [15:0] cmd_seen;
  logic [19:0] strobe_seen;
  int err_total = 0;
  int n_compared = 0;
  aaco_top #(.PHASE_CYC(PC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .analog_out_a_pos(analog_out_a_pos),
    .analog_out_a_neg(analog_out_a_neg), .dac_code_pos(dac_code_pos),
    .dac_code_neg(dac_code_neg), .link_out(link_out), .link_fb(link_fb));
  aaco_drive_model drv (.pclk(pclk), .link_out(link_out), .fb_word(fb_word),
    .link_fb(link_fb), .cmd_seen(cmd_seen), .strobe_seen(strobe_seen));
  // 10 MHz clock
  always #50 pclk = ~pclk;
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, held until pready sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk(e, 0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(e, 32'h0);
    chk(r, x);
  endtask
  // Cycles up to the next rising edge of the PWM pin
  task automatic wait_rise(output int n);
    logic p;
    n = 0;
    do begin
      p = analog_out_a_pos;
      @(posedge pclk);
      n++;
    end while (!(p === 1'b0 && analog_out_a_pos === 1'b1) && n < 2000);
    if (n >= 2000) begin
      err_total++;
      complete_run();
    end
  endtask
  // Waits for a frame to end and the link clock to rest
  task automatic wait_frame_end();
    int n;
    int low;
    logic seen;
    n = 0;
    low = 0;
    while (link_out.sclk !== 1'b1 && n < 2 * PC) begin
      @(posedge pclk);
      n++;
    end
    seen = (link_out.sclk === 1'b1);
    while (seen && low < 20 && n < 4 * PC) begin
      @(posedge pclk);
      n++;
      low = (link_out.sclk === 1'b0) ? low + 1 : 0;
    end
    if (low < 20) begin
      err_total++;
      complete_run();
    end
  endtask
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    chk(dac_code_pos, 16'h8000);
    chk(dac_code_neg, 16'h7fff);
    chk(pready, 32'h1);
    rd(OFS_LINK_CFG, 32'h0000_0205);
    rd(OFS_STROBE, 32'h000f_fffc);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk(e, 32'h1);
    chk(r, 32'h0);
  endtask
  task automatic t_conv();
    logic [15:0] v[4] = '{16'h8000, 16'h0000, 16'h7fff, 16'h0001};
    wr(OFS_CTRL, 32'h1);
    rd(OFS_CTRL, 32'h1);
    foreach (v[i]) begin
      wr(OFS_SETVAL, {16'h0, v[i]});
      rd(OFS_SETVAL, {16'h0, v[i]});
      repeat (PC + 3) @(posedge pclk);
      chk(dac_code_pos, v[i] ^ 16'h8000);
      chk(dac_code_neg, 16'(~(v[i] ^ 16'h8000)));
    end
  endtask
  task automatic t_period();
    int n;
    wr(OFS_SETVAL, 32'h0);
    for (int m = 0; m < 8; m++) begin
      wr(OFS_CTRL, m << 1);
      wait_rise(n);
      wait_rise(n);
      chk(n, (2 * PC) / (m + 1));
    end
  endtask
  task automatic t_duty();
    int hi;
    logic [15:0] s[5] = '{16'hc000, 16'h0000, 16'h3fff, 16'h2000, 16'h4e20};
    int lv[5] = '{0, 16384, 32767, 24576, 32767};
    wr(OFS_CTRL, 32'he);
    foreach (s[i]) begin
      wr(OFS_SETVAL, {16'h0, s[i]});
      repeat (2) @(posedge pclk);
      hi = 0;
      repeat (2 * PC / 8) begin
        @(posedge pclk);
        hi += (analog_out_a_pos === 1'b1);
        chk(analog_out_a_neg, !analog_out_a_pos);
      end
      chk(hi, (lv[i] * (2 * PC / 8)) >> 15);
    end
  endtask
  task automatic t_link();
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CUR_CMD, 32'ha5c3);
    wr(OFS_CUR_FB, 32'h1111);
    repeat (3 * PC) @(posedge pclk);
    wait_frame_end();
    chk(cmd_seen, 16'ha5c3);
    chk(strobe_seen, 20'hffffc);
    rd(OFS_CUR_FB, 32'h3c96);
    wr(OFS_LINK_CFG, 32'h0000_0235);
    rd(OFS_LINK_CFG, 32'h0000_0235);
    wr(OFS_CUR_CMD, 32'h5a3c);
    repeat (2 * PC) @(posedge pclk);
    wait_frame_end();
    chk(cmd_seen, 16'h5a3c);
    chk(strobe_seen, 20'hffffc);
    rd(OFS_CUR_FB, 32'h3c96);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_conv();
    t_period();
    t_duty();
    t_link();
    complete_run();
  end
endmodule
